/* verilog/kbt_pkg.sv */
package kbt_pkg;
  // I/O port numbers and device address
  localparam logic [7:0] PORT_IN_STATUS  = 8'h00;
  localparam logic [7:0] PORT_IN_DATA    = 8'h01;
  localparam logic [7:0] PORT_OUT_SELECT = 8'h01;
  localparam logic [7:0] PORT_OUT_CLEAR  = 8'h03;
  localparam logic [7:0] PORT_OUT_FLAG   = 8'h04;
  localparam logic [7:0] PORT_OUT_CMD1   = 8'h05;
  localparam logic [7:0] PORT_OUT_CMD2   = 8'h06;
  localparam logic [7:0] PORT_OUT_TONE   = 8'h0D;
  localparam logic [7:0] PORT_OUT_CLICK  = 8'h0E;
  localparam logic [7:0] DEVICE_ADDR     = 8'hE1;
  // Status field positions, lamp count, reset code and program load key
  localparam int STAT_AVAIL_BIT   = 7;
  localparam int STAT_TIMEOUT_BIT = 6;
  localparam int LAMP_COUNT       = 4;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [7:0] PROGRAM_LOAD_KEY_KEY_U = 8'hEF;
  localparam logic [15:0] PROGRAM_LOAD_KEY_VECTOR = 16'h8000;
  // Timing
  localparam longint CLK_HZ         = 125000000;
  localparam longint TIMER_MS       = 1000;
  localparam longint TONE_MS        = 1000;
  localparam longint CLICK_US       = 2000;
  localparam longint REPEAT_DELAY_MS = 1000;
  localparam longint REPEAT_PER_S   = 15;
  localparam longint TIMER_CYCLES   = CLK_HZ / 1000 * TIMER_MS;
  localparam longint TONE_CYCLES    = CLK_HZ / 1000 * TONE_MS;
  localparam longint CLICK_CYCLES   = CLK_HZ / 1000000 * CLICK_US;
  localparam longint REPEAT_DELAY_CYCLES = CLK_HZ / 1000 * REPEAT_DELAY_MS;
  localparam longint REPEAT_CYCLES  = CLK_HZ / REPEAT_PER_S;

  typedef struct packed {
    logic       strobe;
    logic       is_out;
    logic [7:0] port;
    logic [7:0] data;
  } kbt_io_t;

  typedef struct packed {
    logic       pressed;
    logic       shift;
    logic       ctrl;
    logic [7:0] code_u;
    logic [7:0] code_s;
    logic [7:0] code_c;
    logic [7:0] code_sc;
  } kbt_key_t;
endpackage

/* verilog/kbt_keyboard_timer.sv */
`timescale 1ns/1ps
module kbt_keyboard_timer #(
  parameter longint TIMER_CYCLES        = kbt_pkg::TIMER_CYCLES,
  parameter longint TONE_CYCLES         = kbt_pkg::TONE_CYCLES,
  parameter longint CLICK_CYCLES        = kbt_pkg::CLICK_CYCLES,
  parameter longint REPEAT_DELAY_CYCLES = kbt_pkg::REPEAT_DELAY_CYCLES,
  parameter longint REPEAT_CYCLES       = kbt_pkg::REPEAT_CYCLES
) (
  input  logic             clk,
  input  logic             rst_b,
  input  kbt_pkg::kbt_io_t io,
  input  kbt_pkg::kbt_key_t key,
  output logic [7:0]       rd_data,
  output logic [3:0]       lamp,
  output logic             tone,
  output logic             click,
  output logic             irq0,
  output logic             program_load_key_load,
  output logic [15:0]      program_load_key_addr
);
  localparam int CW = 28;

  logic [7:0]  sel_reg;
  logic        avail_reg;
  logic        timeout_reg;
  logic        run_reg;
  logic [CW-1:0] tmr_reg;
  logic [CW-1:0] tone_reg;
  logic [CW-1:0] click_reg;
  logic [CW-1:0] rep_reg;
  logic        rep_first_reg;
  logic [7:0]  code_reg;
  logic [3:0]  lamp_reg;
  logic [7:0]  rd_reg;
  logic        program_load_key_reg;
  logic [2:0]  kp_sync_reg;
  logic [1:0]  ks_sync_reg;
  logic [1:0]  kc_sync_reg;
  logic [7:0]  kcode;
  logic        selected;
  logic        wr;
  logic        rd;
  logic        is_program_load_key;
  logic        key_event;
  logic        expire;
  logic        op_sel;
  logic        op_status;
  logic        op_data;
  logic        op_clear;
  logic        op_flag;
  logic        op_cmd1;
  logic        op_cmd2;
  logic        op_tone;
  logic        op_click;
  logic [3:0][7:0] key_codes;
  logic [3:0][7:0] code_meta_reg;
  logic [3:0][7:0] code_sync_reg;
  genvar       gi;

  assign wr = io.strobe & io.is_out;
  assign rd = io.strobe & ~io.is_out;
  assign selected = (sel_reg == kbt_pkg::DEVICE_ADDR);

  // port decode; device ports need the selection
  assign op_status = rd && selected && io.port == kbt_pkg::PORT_IN_STATUS;
  assign op_data   = rd && selected && io.port == kbt_pkg::PORT_IN_DATA;
  assign op_clear  = wr && selected && io.port == kbt_pkg::PORT_OUT_CLEAR;
  assign op_flag   = wr && selected && io.port == kbt_pkg::PORT_OUT_FLAG;
  assign op_cmd1   = wr && selected && io.port == kbt_pkg::PORT_OUT_CMD1;
  assign op_cmd2   = wr && selected && io.port == kbt_pkg::PORT_OUT_CMD2;

  assign op_sel    = wr && io.port == kbt_pkg::PORT_OUT_SELECT;
  assign op_tone   = wr && io.port == kbt_pkg::PORT_OUT_TONE;
  assign op_click  = wr && io.port == kbt_pkg::PORT_OUT_CLICK;

  always_ff @(posedge clk)
    if (!rst_b)
      sel_reg <= 8'h00;
    // Any other address deselects the keyboard
    else if (op_sel)
      sel_reg <= io.data;

  // Key pins are asynchronous: two flops before use
  always_ff @(posedge clk)
    if (!rst_b)
    begin
      kp_sync_reg <= 3'h0;
      ks_sync_reg <= 2'h0;
      kc_sync_reg <= 2'h0;
    end
    else
    begin
      kp_sync_reg <= {kp_sync_reg[1:0], key.pressed};
      ks_sync_reg <= {ks_sync_reg[0], key.shift};
      kc_sync_reg <= {kc_sync_reg[0], key.ctrl};
    end

  // Code pins are asynchronous as well; they settle before the press edge is seen
  assign key_codes = {key.code_u, key.code_s, key.code_c, key.code_sc};
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_code_sync
      always_ff @(posedge clk)
        if (!rst_b)
        begin
          code_meta_reg[gi] <= 8'h00;
          code_sync_reg[gi] <= 8'h00;
        end
        else
        begin
          code_meta_reg[gi] <= key_codes[gi];
          code_sync_reg[gi] <= code_meta_reg[gi];
        end
    end
  endgenerate

  always_comb
    case ({ks_sync_reg[1], kc_sync_reg[1]})
      2'b00:   kcode = code_sync_reg[3];
      2'b10:   kcode = code_sync_reg[2];
      2'b01:   kcode = code_sync_reg[1];
      default: kcode = code_sync_reg[0];
    endcase

  assign is_program_load_key = (code_sync_reg[3] == kbt_pkg::PROGRAM_LOAD_KEY_KEY_U) & ks_sync_reg[1] & kc_sync_reg[1];

  always_ff @(posedge clk)
    if (!rst_b)
    begin
      rep_reg <= '0;
      rep_first_reg <= 1'b0;
    end
    else if (!kp_sync_reg[1])
    begin
      rep_reg <= '0;
      rep_first_reg <= 1'b0;
    end
    else if (!kp_sync_reg[2])
    begin
      rep_reg <= CW'(REPEAT_DELAY_CYCLES - 1);
      rep_first_reg <= 1'b1;
    end
    // Every later expiry reloads the shorter repeat period
    else if (rep_reg == '0)
    begin
      rep_reg <= CW'(REPEAT_CYCLES - 1);
      rep_first_reg <= 1'b0;
    end
    else
      rep_reg <= rep_reg - 1'b1;

  // Press edge or repeat expiry; repeat keys are codes too, never program load
  assign key_event = kp_sync_reg[1] & (~kp_sync_reg[2] | (rep_reg == '0)) & ~is_program_load_key;

  // Registered so the load request is a single-cycle pulse
  always_ff @(posedge clk)
    if (!rst_b)
      program_load_key_reg <= 1'b0;
    else
      program_load_key_reg <= kp_sync_reg[1] & ~kp_sync_reg[2] & is_program_load_key;

  // code latch and available flag; new key wins over read
  always_ff @(posedge clk)
    if (!rst_b)
    begin
      code_reg  <= kbt_pkg::CODE_RESET;
      avail_reg <= 1'b0;
    end
    else if (key_event)
    begin
      code_reg  <= kcode;
      avail_reg <= 1'b1;
    end
    // Clear loses to a key arriving in the same cycle
    else if (op_clear)
    begin
      code_reg  <= kbt_pkg::CODE_RESET;
      avail_reg <= 1'b0;
    end
    else if (op_data)
      avail_reg <= 1'b0;

  assign expire = run_reg & (tmr_reg == '0);
  always_ff @(posedge clk)
    if (!rst_b)
    begin
      run_reg <= 1'b0;
      tmr_reg <= '0;
    end
    // Restart: a fresh full interval, never the remainder
    else if (op_cmd1)
    begin
      run_reg <= 1'b1;
      tmr_reg <= CW'(TIMER_CYCLES - 1);
    end
    // Cancel and clear leave the timer idle at zero
    else if (op_cmd2 || op_clear)
    begin
      run_reg <= 1'b0;
      tmr_reg <= '0;
    end
    else if (expire)
      run_reg <= 1'b0;
    else if (run_reg)
      tmr_reg <= tmr_reg - 1'b1;

  // timeout flag; expiry wins over a clear in the same cycle
  always_ff @(posedge clk)
    if (!rst_b)
      timeout_reg <= 1'b0;
    else if (expire)
      timeout_reg <= 1'b1;
    // Either timer command drops a pending timeout
    else if (op_cmd1 || op_cmd2 || op_clear)
      timeout_reg <= 1'b0;

  // lamps, one flop per function key; bits 7..4 never reach them
  generate
    for (gi = 0; gi < kbt_pkg::LAMP_COUNT; gi++)
    begin : g_lamp
      always_ff @(posedge clk)
        if (!rst_b)
          lamp_reg[gi] <= 1'b0;
        else if (op_flag)
          lamp_reg[gi] <= io.data[gi];
    end
  endgenerate

  always_ff @(posedge clk)
    if (!rst_b)
      tone_reg <= '0;
    // A repeated tone command restarts the full second
    else if (op_tone)
      tone_reg <= CW'(TONE_CYCLES);
    else if (tone_reg != '0)
      tone_reg <= tone_reg - 1'b1;

  always_ff @(posedge clk)
    if (!rst_b)
      click_reg <= '0;
    // Click length is a free choice, kept short
    else if (op_click)
      click_reg <= CW'(CLICK_CYCLES);
    else if (click_reg != '0)
      click_reg <= click_reg - 1'b1;

  // read mux; unselected or unknown reads give zero
  // Reads return flags as they stood before this cycle's updates
  always_ff @(posedge clk)
    if (!rst_b)
      rd_reg <= 8'h00;
    else if (op_status)
    begin
      rd_reg <= 8'h00;
      rd_reg[kbt_pkg::STAT_AVAIL_BIT]   <= avail_reg;
      rd_reg[kbt_pkg::STAT_TIMEOUT_BIT] <= timeout_reg;
    end
    else if (op_data)
      rd_reg <= code_reg;
    else if (rd)
      rd_reg <= 8'h00;

  assign irq0      = avail_reg | timeout_reg;
  assign rd_data   = rd_reg;
  assign lamp      = lamp_reg;
  assign tone      = (tone_reg != '0);
  assign click     = (click_reg != '0);
  assign program_load_key_load = program_load_key_reg;
  assign program_load_key_addr = kbt_pkg::PROGRAM_LOAD_KEY_VECTOR;
endmodule

/* verification/kbt_cpu_model.sv */
`timescale 1ns/1ps
module kbt_cpu_model (
  input  logic             clk,
  output kbt_pkg::kbt_io_t io
);
  initial io = '0;
  task automatic op(logic o, logic [7:0] p, logic [7:0] d);
    @(posedge clk);
    io <= '{1'b1, o, p, d};
    @(posedge clk);
    // Released bus shows inverted port and data, never the stale ones
    io <= '{1'b0, o, ~p, ~d};
  endtask
endmodule

/* verification/kbt_asserts.sv */
`timescale 1ns/1ps
module kbt_asserts #(parameter longint TIMER_CYCLES = 20) (
  input logic             clk,
  input logic             rst_b,
  input kbt_pkg::kbt_io_t io,
  input logic [7:0]       rd_data,
  input logic [3:0]       lamp,
  input logic             tone,
  input logic             irq0,
  input logic             program_load_key_load,
  input logic [15:0]      program_load_key_addr
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic sel_reg;
  int   cnt_reg;
  wire  dev = sel_reg && io.strobe && io.is_out;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sel_reg <= 1'b0;
    else if (io.strobe && io.is_out && io.port == 8'h01)
      sel_reg <= io.data == 8'hE1;
  end
  // Counts cycles since the last accepted timer start
  always_ff @(posedge clk)
  begin
    if (!rst_b || (dev && (io.port == 8'h03 || io.port == 8'h06)))
      cnt_reg <= 0;
    else if (dev && io.port == 8'h05)
      cnt_reg <= 1;
    else if (cnt_reg != 0)
      cnt_reg <= cnt_reg + 1;
  end
  sequence s_dev(logic o, logic [7:0] p);
    sel_reg && io.strobe && io.is_out == o && io.port == p;
  endsequence
  property p_tone;
    io.strobe && io.is_out && io.port == 8'h0D |=> tone [*8];
  endproperty
  property p_lamp;
    s_dev(1'b1, 8'h04) |=> lamp == $past(io.data[3:0]);
  endproperty
  property p_stat;
    s_dev(1'b0, 8'h00) |=> rd_data[5:0] == 6'h00 && (|rd_data[7:6]) == $past(irq0);
  endproperty
  property p_unsel;
    !sel_reg && io.strobe && !io.is_out |=> rd_data == 8'h00;
  endproperty
  property p_timer;
    cnt_reg == TIMER_CYCLES + 2 |-> irq0;
  endproperty
  property p_pulse;
    program_load_key_load |=> !program_load_key_load;
  endproperty
  property p_addr;
    program_load_key_addr == 16'h8000;
  endproperty
  property p_hold;
    !io.strobe || io.is_out |=> $stable(rd_data);
  endproperty
  a_tone: assert property (p_tone) else $error("tone too short");
  a_lamp: assert property (p_lamp) else $error("lamp mismatch");
  a_stat: assert property (p_stat) else $error("status mismatch");
  a_unsel: assert property (p_unsel) else $error("unselected read");
  a_timer: assert property (p_timer) else $error("no timeout");
  a_pulse: assert property (p_pulse) else $error("long pulse");
  a_addr: assert property (p_addr) else $error("load address");
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind kbt_keyboard_timer kbt_asserts #(.TIMER_CYCLES(TIMER_CYCLES)) u_chk (
  .clk(clk), .rst_b(rst_b), .io(io), .rd_data(rd_data), .lamp(lamp), .tone(tone),
  .irq0(irq0), .program_load_key_load(program_load_key_load), .program_load_key_addr(program_load_key_addr));

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  kbt_pkg::kbt_io_t  io;
  kbt_pkg::kbt_key_t key = '0;
  logic [7:0]        rd_data;
  logic [3:0]        lamp;
  logic              tone, click, irq0, program_load_key_load;
  logic [15:0]       program_load_key_addr;
  int                miscompares = 0;
  int                n_checks = 0;
  always #4 clk = ~clk;
  kbt_cpu_model cpu (.clk(clk), .io(io));
  kbt_keyboard_timer #(.TIMER_CYCLES(20), .TONE_CYCLES(20), .CLICK_CYCLES(5),
    .REPEAT_DELAY_CYCLES(30), .REPEAT_CYCLES(10)) uut (.clk(clk), .rst_b(rst_b), .io(io),
    .key(key), .rd_data(rd_data), .lamp(lamp), .tone(tone), .click(click), .irq0(irq0),
    .program_load_key_load(program_load_key_load), .program_load_key_addr(program_load_key_addr));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(logic [7:0] p, logic [7:0] exp);
    cpu.op(1'b0, p, 8'h00);
    #1 chk(rd_data, exp);
  endtask
  task automatic wirq(int n);
    repeat (n)
    begin
      @(posedge clk);
      #1 if (irq0 === 1'b1) return;
    end
    miscompares++;
    complete_run();
  endtask
  task automatic press(logic s, logic c, logic [31:0] codes);
    @(posedge clk);
    key <= {1'b1, s, c, codes};
  endtask
  task automatic lift();
    repeat (4) @(posedge clk);
    key <= {3'b000, ~key[31:0]};
    repeat (4) @(posedge clk);
  endtask
  task automatic t_ports();
    rd(8'h00, 8'h00);
    cpu.op(1'b1, 8'h04, 8'h0F);
    cpu.op(1'b1, 8'h0D, 8'h00);
    #1 chk({tone, lamp}, 5'h10);
    cpu.op(1'b1, 8'h0E, 8'h00);
    #1 chk(click, 1'b1);
    cpu.op(1'b1, 8'h01, 8'hE1);
    cpu.op(1'b1, 8'h04, 8'hF5);
    #1 chk(lamp, 4'h5);
  endtask
  task automatic t_codes();
    logic [7:0] want [4] = '{8'h31, 8'h21, 8'hB1, 8'hA1};
    for (int i = 0; i < 4; i++)
    begin
      press(i[0], i[1], 32'h3121B1A1);
      wirq(8);
      rd(8'h00, 8'h80);
      rd(8'h01, want[i]);
      lift();
      chk(irq0, 1'b0);
    end
  endtask
  task automatic t_overwrite();
    press(1'b0, 1'b0, 32'h3121B1A1);
    lift();
    press(1'b1, 1'b0, 32'h3121B1A1);
    lift();
    cpu.op(1'b1, 8'h01, 8'hF0);
    rd(8'h00, 8'h00);
    chk(irq0, 1'b1);
    cpu.op(1'b1, 8'h01, 8'hE1);
    rd(8'h01, 8'h21);
  endtask
  task automatic t_repeat();
    press(1'b0, 1'b0, 32'h3121B1A1);
    wirq(8);
    rd(8'h01, 8'h31);
    repeat (15) @(posedge clk);
    #1 chk(irq0, 1'b0);
    wirq(20);
    rd(8'h01, 8'h31);
    wirq(14);
    lift();
    rd(8'h01, 8'h31);
    repeat (20) @(posedge clk);
    #1 chk(irq0, 1'b0);
  endtask
  task automatic t_timer();
    cpu.op(1'b1, 8'h05, 8'h00);
    repeat (10) @(posedge clk);
    cpu.op(1'b1, 8'h05, 8'h00);
    repeat (13) @(posedge clk);
    #1 chk(irq0, 1'b0);
    wirq(12);
    rd(8'h00, 8'h40);
    cpu.op(1'b1, 8'h05, 8'h00);
    #1 chk(irq0, 1'b0);
    wirq(25);
    cpu.op(1'b1, 8'h06, 8'h00);
    #1 chk(irq0, 1'b0);
    repeat (30) @(posedge clk);
    rd(8'h00, 8'h00);
  endtask
  task automatic t_clear();
    press(1'b0, 1'b0, 32'h3121B1A1);
    cpu.op(1'b1, 8'h05, 8'h00);
    lift();
    repeat (16) @(posedge clk);
    rd(8'h00, 8'hC0);
    cpu.op(1'b1, 8'h03, 8'h00);
    #1 chk(irq0, 1'b0);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
  endtask
  task automatic t_program_load_key();
    press(1'b1, 1'b1, 32'hEFFFED00);
    repeat (8)
    begin
      @(posedge clk);
      #1 if (program_load_key_load === 1'b1) break;
    end
    chk({program_load_key_load, program_load_key_addr[14:0]}, 16'h8000);
    lift();
    chk(irq0, 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk({tone, click, irq0, program_load_key_load, lamp, rd_data}, 16'h0000);
    t_ports();
    t_codes();
    t_overwrite();
    t_repeat();
    t_timer();
    t_clear();
    t_program_load_key();
    complete_run();
  end
endmodule
